// *** design/shb_pkg.sv ***
// Purpose: Shared constants and types of the snapshot histogram binning block.
// Assumes: 16-bit register fields in the low half of the APB word, except the 32-bit bin count read.
// Notes:   Register constants are word indices; byte address is index * 4.
package shb_pkg;
   localparam int DAT_W = 16;
   localparam int BIN_W = 10;
   localparam int CNT_W = 32;
   localparam int BINS  = 1024;

   localparam logic [7:0] IDX_CTRL   = 8'h70;
   localparam logic [7:0] IDX_STAT   = 8'h71;
   localparam logic [7:0] IDX_LOWER  = 8'h74;
   localparam logic [7:0] IDX_UPPER  = 8'h75;
   localparam logic [7:0] IDX_SHIFT  = 8'h76;
   localparam logic [7:0] IDX_TOTAL  = 8'h77;
   localparam logic [7:0] IDX_IFLAG  = 8'h7a;
   localparam logic [7:0] IDX_IMASK  = 8'h7b;
   localparam logic [7:0] IDX_BINSEL = 8'h7c;
   localparam logic [7:0] IDX_BINCNT = 8'h7d;
   localparam logic [7:0] IDX_PERGRP = 8'h7e;

   localparam logic [15:0] RST_ZERO   = 16'h0000;
   localparam logic [15:0] RST_PERGRP = 16'hffff;

   localparam int CMD_CLR_BIT = 1;
   localparam int MODE_LSB    = 6;
   localparam logic [1:0] CMD_OFF     = 2'h0;
   localparam logic [1:0] CMD_ENABLE  = 2'h1;
   localparam logic [1:0] MODE_CAPT   = 2'h0;
   localparam logic [1:0] MODE_I      = 2'h1;
   localparam logic [1:0] MODE_Q      = 2'h2;
   localparam logic [1:0] MODE_PWR    = 2'h3;
   localparam logic [15:0] CTRL_MASK  = 16'h00ff;

   localparam logic [2:0] STAT_OFF    = 3'h0;
   localparam logic [2:0] STAT_WAIT   = 3'h1;
   localparam logic [2:0] STAT_ACTIVE = 3'h2;
   localparam logic [2:0] STAT_DONE   = 3'h3;
   localparam logic [2:0] STAT_CLEAR  = 3'h4;

   localparam int IRQ_DONE = 0;
   localparam int IRQ_OVF  = 2;
   localparam int IRQ_W    = 3;

   localparam logic [9:0]  BIN_LAST = 10'h3ff;
   localparam logic [15:0] SIGN_FLIP = 16'h8000;

   typedef enum logic [2:0] {
      ST_OFF    = 3'b000,
      ST_WAIT   = 3'b001,
      ST_ACTIVE = 3'b011,
      ST_DONE   = 3'b010,
      ST_CLEAR  = 3'b110
   } shb_state_type;

   typedef struct packed {
      logic              valid;
      logic [DAT_W-1:0]  i;
      logic [DAT_W-1:0]  q;
   } shb_smp_type;

   typedef struct packed {
      logic              psel;
      logic              penable;
      logic              pwrite;
      logic [11:0]       paddr;
      logic [31:0]       pwdata;
   } shb_apb_req_type;
endpackage : shb_pkg

// *** design/shb_bin_index.sv ***
// Purpose: Turns one order-mapped sample into a histogram bin number.
// Assumes: Value and bounds are already mapped to unsigned ordering.
// Notes:   Purely combinational; the caller registers the result.
`timescale 1ns/1ps
`default_nettype none
module shb_bin_index (
   input  wire logic [15:0] value,     // Sample value, unsigned order
   input  wire logic [15:0] lower,     // Lower bound, unsigned order
   input  wire logic [15:0] upper,     // Upper bound, unsigned order
   input  wire logic [2:0]  shift_sel, // Window select, 1 takes bits 9:0
   output logic      [9:0]  bin        // Resulting bin number
);
   logic [15:0] diff;
   logic [15:0] shifted;
   logic [2:0]  amount;

   always_comb begin
      diff    = value - lower;
      // A select of zero is treated like one, so the window never underflows.
      amount  = (shift_sel == 3'h0) ? 3'h0 : shift_sel - 3'h1; // [RULE_04]
      shifted = diff >> amount;                                // [RULE_05]
      if (value <= lower) begin
         bin = 10'h000;                                        // [RULE_01] [RULE_14]
      end else if (value >= upper) begin
         bin = shb_pkg::BIN_LAST;                              // [RULE_02] [RULE_14]
      end else begin
         // Bits above the window are dropped; software keeps them zero.
         bin = shifted[9:0];                                   // [RULE_06] [RULE_07]
      end
   end
endmodule : shb_bin_index
`default_nettype wire

// *** design/shb_top.sv ***
// Purpose: Histogram binning and run counting for the second snapshot RAM.
// Assumes: Samples come from logic on pclk; APB master on pclk.
// Notes:   APB answers with one wait state; bins are read through a window.
`timescale 1ns/1ps
`default_nettype none
// Operation
// RULE_01 - Values at or below the lower bound count into bin 0.
// RULE_02 - Values at or above the upper bound count into bin 1023.
// RULE_03 - Bounds, shift and run length only act in histogram modes; an active run still counts to its end after a switch to capture mode.
// RULE_04 - Shift select 1 takes difference bits 9:0, up to 15:6 at 7.
// RULE_05 - In-range samples: subtract lower, shift, increment that bin.
// RULE_06 - Software keeps every computed index inside 0 to 1023.
// RULE_07 - There are 1024 bins, the shift compresses range into 10 bits.
// RULE_08 - A run ends after samples per group times group total samples.
// RULE_09 - Samples per group is 16 bits and resets to all ones.
// RULE_10 - Mode field bins I, Q or I squared plus Q squared.
// RULE_11 - Software clears the RAM with command 2 before a run.
// RULE_12 - A run starts only on the capture sync event, never a timer.
// RULE_13 - A 32-bit bin overflow sets flag bit 2, interrupting if unmasked.
// RULE_14 - Out-of-bound samples are clamped into the end bins, not dropped.
module shb_top (
   input  wire logic                   pclk,      // Sample and bus clock
   input  wire logic                   presetn,   // Async reset, active low
   input  wire shb_pkg::shb_apb_req_type apb,     // APB request signals
   output logic [31:0]                 prdata,    // APB read data
   output logic                        pready,    // APB ready
   output logic                        pslverr,   // APB error, unmapped
   input  wire shb_pkg::shb_smp_type   smp,       // Monitored sample
   input  wire logic                   snap_sync, // Capture sync event pulse
   output logic                        irq,       // Level interrupt
   output logic [2:0]                  status     // Current run status
);
   shb_pkg::shb_state_type state_r;
   logic [15:0] ctrl_r;
   logic [15:0] lower_r;
   logic [15:0] upper_r;
   logic [2:0]  shift_r;
   logic [15:0] total_r;
   logic [15:0] pergrp_r;
   logic [2:0]  iflag_r;
   logic [2:0]  iflag_nxt;
   logic [2:0]  imask_r;
   logic [9:0]  binsel_r;
   logic [9:0]  clr_cnt_r;
   logic [15:0] smp_cnt_r;
   logic [15:0] grp_cnt_r;
   logic        a_vld_r;
   logic [15:0] a_val_r;
   logic        b_vld_r;
   logic [9:0]  b_bin_r;
   logic [9:0]  bin_calc;
   logic [31:0] mem [0:shb_pkg::BINS-1];   // One 32-bit counter per bin
   logic [31:0] rd_val;
   logic        rd_ok;
   logic [7:0]  widx;
   logic        acc;
   logic        wr;
   logic        wr_ctrl;
   logic        clear_req;
   logic        hist_mode;
   logic        last_smp;
   logic        done_ev;
   logic        ovf_ev;
   logic [15:0] lower_m;
   logic [15:0] upper_m;
   logic [15:0] sel_val;
   logic [31:0] pwr;
   logic [1:0]  mode;
   logic [31:0] b_cnt;

   assign widx      = apb.paddr[9:2];
   assign acc       = apb.psel & apb.penable & pready;
   assign wr        = acc & apb.pwrite;
   assign wr_ctrl   = wr && (widx == shb_pkg::IDX_CTRL) && rd_ok;
   assign mode      = ctrl_r[shb_pkg::MODE_LSB +: 2];
   assign hist_mode = (mode != shb_pkg::MODE_CAPT);               // [RULE_03]
   assign clear_req = wr_ctrl && apb.pwdata[shb_pkg::CMD_CLR_BIT]; // [RULE_11]
   assign b_cnt     = mem[b_bin_r];

   // Signed I and Q are offset so that an unsigned compare orders them.
   always_comb begin
      pwr = $signed(smp.i) * $signed(smp.i) + $signed(smp.q) * $signed(smp.q);
      case (mode)                                                 // [RULE_10]
         shb_pkg::MODE_I: sel_val = smp.i ^ shb_pkg::SIGN_FLIP;
         shb_pkg::MODE_Q: sel_val = smp.q ^ shb_pkg::SIGN_FLIP;
         default:         sel_val = pwr[31:16];
      endcase
      if (mode == shb_pkg::MODE_PWR) begin
         lower_m = lower_r;
         upper_m = upper_r;
      end else begin
         lower_m = lower_r ^ shb_pkg::SIGN_FLIP;
         upper_m = upper_r ^ shb_pkg::SIGN_FLIP;
      end
   end

   always_comb begin
      last_smp = (smp_cnt_r == pergrp_r - 16'h1) &&
                 (grp_cnt_r == total_r - 16'h1);                  // [RULE_08]
      done_ev  = (state_r == shb_pkg::ST_ACTIVE) && smp.valid &&
                 last_smp && !clear_req;
      ovf_ev   = b_vld_r && (state_r != shb_pkg::ST_CLEAR) &&
                 (b_cnt == 32'hffffffff);                         // [RULE_13]
   end

   // Run state.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_r <= shb_pkg::ST_OFF;
      end else begin
         case (state_r)
            shb_pkg::ST_OFF: begin
               if (clear_req) begin
                  state_r <= shb_pkg::ST_CLEAR;
               end else if (ctrl_r[1:0] == shb_pkg::CMD_ENABLE && hist_mode) begin
                  state_r <= shb_pkg::ST_WAIT;
               end
            end
            shb_pkg::ST_WAIT: begin
               if (clear_req) begin
                  state_r <= shb_pkg::ST_CLEAR;
               end else if (ctrl_r[1:0] != shb_pkg::CMD_ENABLE || !hist_mode) begin
                  state_r <= shb_pkg::ST_OFF;
               end else if (snap_sync) begin                      // [RULE_12]
                  if (pergrp_r == 16'h0 || total_r == 16'h0) begin
                     state_r <= shb_pkg::ST_DONE;
                  end else begin
                     state_r <= shb_pkg::ST_ACTIVE;
                  end
               end
            end
            shb_pkg::ST_ACTIVE: begin
               if (clear_req) begin
                  state_r <= shb_pkg::ST_CLEAR;
               end else if (ctrl_r[1:0] != shb_pkg::CMD_ENABLE) begin
                  state_r <= shb_pkg::ST_OFF;
               end else if (done_ev) begin                        // [RULE_08]
                  state_r <= shb_pkg::ST_DONE;
               end
            end
            shb_pkg::ST_DONE: begin
               if (clear_req) begin
                  state_r <= shb_pkg::ST_CLEAR;
               end else if (ctrl_r[1:0] != shb_pkg::CMD_ENABLE) begin
                  state_r <= shb_pkg::ST_OFF;
               end
            end
            shb_pkg::ST_CLEAR: begin
               if (clr_cnt_r == shb_pkg::BIN_LAST) begin
                  state_r <= shb_pkg::ST_OFF;
               end
            end
            default: state_r <= shb_pkg::ST_OFF;
         endcase
      end
   end

   // Clear sweep address and run counters.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         clr_cnt_r <= 10'h000;
         smp_cnt_r <= 16'h0000;
         grp_cnt_r <= 16'h0000;
      end else begin
         clr_cnt_r <= (state_r == shb_pkg::ST_CLEAR) ? clr_cnt_r + 10'h1 : 10'h000;
         if (state_r != shb_pkg::ST_ACTIVE) begin
            smp_cnt_r <= 16'h0000;
            grp_cnt_r <= 16'h0000;
         end else if (smp.valid) begin
            if (smp_cnt_r == pergrp_r - 16'h1) begin
               smp_cnt_r <= 16'h0000;
               grp_cnt_r <= grp_cnt_r + 16'h1;
            end else begin
               smp_cnt_r <= smp_cnt_r + 16'h1;
            end
         end
      end
   end

   shb_bin_index u_index (
      .value     (a_val_r),
      .lower     (lower_m),
      .upper     (upper_m),
      .shift_sel (shift_r),
      .bin       (bin_calc)
   );

   // Two-stage pipe: pick the value, then the bin.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         a_vld_r <= 1'b0;
         a_val_r <= 16'h0000;
         b_vld_r <= 1'b0;
         b_bin_r <= 10'h000;
      end else begin
         a_vld_r <= (state_r == shb_pkg::ST_ACTIVE) && smp.valid && hist_mode;
         a_val_r <= sel_val;
         b_vld_r <= a_vld_r;
         b_bin_r <= bin_calc;
      end
   end

   // Counters wrap on overflow; the clear sweep drops any increment in flight.
   always_ff @(posedge pclk) begin
      if (state_r == shb_pkg::ST_CLEAR) begin
         mem[clr_cnt_r] <= 32'h00000000;
      end else if (b_vld_r) begin
         mem[b_bin_r] <= b_cnt + 32'h1;                           // [RULE_05]
      end
   end

   // Configuration registers; control ignores writes while clearing.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_r   <= shb_pkg::RST_ZERO;
         lower_r  <= shb_pkg::RST_ZERO;
         upper_r  <= shb_pkg::RST_ZERO;
         shift_r  <= 3'h0;
         total_r  <= shb_pkg::RST_ZERO;
         pergrp_r <= shb_pkg::RST_PERGRP;                         // [RULE_09]
         imask_r  <= 3'h0;
         binsel_r <= 10'h000;
      end else begin
         if (state_r == shb_pkg::ST_CLEAR && clr_cnt_r == shb_pkg::BIN_LAST) begin
            ctrl_r[1:0] <= shb_pkg::CMD_OFF;
         end else if (wr_ctrl && state_r != shb_pkg::ST_CLEAR) begin
            ctrl_r <= apb.pwdata[15:0] & shb_pkg::CTRL_MASK;
         end
         if (wr && rd_ok) begin
            case (widx)
               shb_pkg::IDX_LOWER:  lower_r  <= apb.pwdata[15:0];
               shb_pkg::IDX_UPPER:  upper_r  <= apb.pwdata[15:0];
               shb_pkg::IDX_SHIFT:  shift_r  <= apb.pwdata[2:0];  // [RULE_04]
               shb_pkg::IDX_TOTAL:  total_r  <= apb.pwdata[15:0]; // [RULE_08]
               shb_pkg::IDX_PERGRP: pergrp_r <= apb.pwdata[15:0]; // [RULE_09]
               shb_pkg::IDX_IMASK:  imask_r  <= apb.pwdata[2:0];
               shb_pkg::IDX_BINSEL: binsel_r <= apb.pwdata[9:0];
               default: ;
            endcase
         end
      end
   end

   // Sticky flags: write one to clear, a new event wins over the clear.
   always_comb begin
      iflag_nxt = iflag_r;
      if (wr && widx == shb_pkg::IDX_IFLAG && apb.paddr[11:10] == 2'h0) begin
         iflag_nxt = iflag_r & ~apb.pwdata[2:0];
      end
      iflag_nxt[shb_pkg::IRQ_DONE] = iflag_nxt[shb_pkg::IRQ_DONE] | done_ev;
      iflag_nxt[shb_pkg::IRQ_OVF]  = iflag_nxt[shb_pkg::IRQ_OVF] | ovf_ev; // [RULE_13]
      iflag_nxt[1] = 1'b0;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         iflag_r <= 3'h0;
         irq     <= 1'b0;
      end else begin
         iflag_r <= iflag_nxt;
         irq     <= |(iflag_r & imask_r);                         // [RULE_13]
      end
   end

   always_comb begin
      rd_ok  = (apb.paddr[11:10] == 2'h0);
      rd_val = 32'h00000000;
      case (widx)
         shb_pkg::IDX_CTRL:   rd_val = {16'h0000, ctrl_r};
         shb_pkg::IDX_STAT:   rd_val = {29'h0, status};
         shb_pkg::IDX_LOWER:  rd_val = {16'h0000, lower_r};
         shb_pkg::IDX_UPPER:  rd_val = {16'h0000, upper_r};
         shb_pkg::IDX_SHIFT:  rd_val = {29'h0, shift_r};
         shb_pkg::IDX_TOTAL:  rd_val = {16'h0000, total_r};
         shb_pkg::IDX_PERGRP: rd_val = {16'h0000, pergrp_r};
         shb_pkg::IDX_IFLAG:  rd_val = {29'h0, iflag_r};
         shb_pkg::IDX_IMASK:  rd_val = {29'h0, imask_r};
         shb_pkg::IDX_BINSEL: rd_val = {22'h0, binsel_r};
         shb_pkg::IDX_BINCNT: rd_val = mem[binsel_r];
         default:             rd_ok  = 1'b0;
      endcase
   end

   // APB slave with one wait state; data and error are set with ready.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         prdata  <= 32'h00000000;
         pslverr <= 1'b0;
         status  <= shb_pkg::STAT_OFF;
      end else begin
         pready <= apb.psel & apb.penable & ~pready;
         if (apb.psel & apb.penable & ~pready) begin
            prdata  <= apb.pwrite ? 32'h00000000 : rd_val;
            pslverr <= ~rd_ok | (apb.pwrite && widx == shb_pkg::IDX_STAT);
         end else begin
            pslverr <= 1'b0;
         end
         case (state_r)
            shb_pkg::ST_WAIT:   status <= shb_pkg::STAT_WAIT;
            shb_pkg::ST_ACTIVE: status <= shb_pkg::STAT_ACTIVE;
            shb_pkg::ST_DONE:   status <= shb_pkg::STAT_DONE;
            shb_pkg::ST_CLEAR:  status <= shb_pkg::STAT_CLEAR;
            default:            status <= shb_pkg::STAT_OFF;
         endcase
      end
   end

   // Checks.
   logic        chk_vld_r;
   logic [9:0]  chk_bin_r;
   logic [31:0] chk_val_r;
   logic [10:0] chk_clr_r;
   logic [15:0] a_diff;
   assign a_diff = a_val_r - lower_m;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         chk_vld_r <= 1'b0;
         chk_bin_r <= 10'h000;
         chk_val_r <= 32'h00000000;
         chk_clr_r <= 11'h000;
      end else begin
         // Counts clear cycles independently of the sweep address.
         chk_clr_r <= (state_r == shb_pkg::ST_CLEAR) ? chk_clr_r + 11'h1 :
                      11'h000;
         chk_vld_r <= b_vld_r && (state_r != shb_pkg::ST_CLEAR);
         chk_bin_r <= b_bin_r;
         chk_val_r <= b_cnt + 32'h1;
      end
   end

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   clamp_low_a: assert property (a_vld_r && a_val_r <= lower_m |=> // [RULE_01]
      b_bin_r == 10'h000) else $error("low sample not in bin 0");
   clamp_high_a: assert property (a_vld_r && a_val_r > lower_m && // [RULE_02]
      a_val_r >= upper_m |=> b_bin_r == 10'h3ff)
      else $error("high sample not in last bin");
   capture_idle_a: assert property (mode == 2'h0 |=> !a_vld_r) // [RULE_03]
      else $error("sample binned in capture mode");
   shift_window_a: assert property (a_vld_r && a_val_r > lower_m && // [RULE_04]
      a_val_r < upper_m && shift_r == 3'h7 && $stable(lower_m)
      |=> b_bin_r == $past(a_diff[15:6])) else $error("shift window wrong");
   bin_increment_a: assert property (chk_vld_r |-> // [RULE_05]
      mem[chk_bin_r] == chk_val_r) else $error("bin not incremented");
   run_end_a: assert property (done_ev && ctrl_r[1:0] == 2'h1 |=> // [RULE_08]
      state_r == shb_pkg::ST_DONE ##1 status == 3'h3)
      else $error("run did not end");
   pergrp_hold_a: assert property (!(wr && widx == 8'h7e) |=> // [RULE_09]
      $stable(pergrp_r)) else $error("group size changed without write");
   mode_i_a: assert property (state_r == shb_pkg::ST_ACTIVE && smp.valid && // [RULE_10]
      mode == 2'h1 |=> a_vld_r && a_val_r == ($past(smp.i) ^ 16'h8000))
      else $error("I value not selected");
   sync_wait_a: assert property (state_r == shb_pkg::ST_WAIT && !snap_sync && // [RULE_12]
      !clear_req && ctrl_r[1:0] == 2'h1 && mode != 2'h0 |=>
      state_r == shb_pkg::ST_WAIT) else $error("run began without sync");
   ovf_flag_a: assert property (ovf_ev |=> iflag_r[2] ##1 // [RULE_13]
      (irq == imask_r[2] || $past(iflag_r[0] & imask_r[0]) || !iflag_r[2]))
      else $error("overflow flag not set");
   clear_len_a: assert property (state_r == shb_pkg::ST_CLEAR |=> // [RULE_07]
      (state_r == shb_pkg::ST_CLEAR) == (chk_clr_r != 11'h400))
      else $error("clear sweep not 1024 bins");

   run_done_c: cover property (done_ev);
   overflow_c: cover property (ovf_ev);
   clear_end_c: cover property ($fell(state_r == shb_pkg::ST_CLEAR));
   clamp_top_c: cover property (b_vld_r && b_bin_r == 10'h3ff);
endmodule : shb_top
`default_nettype wire

// *** sim/shb_sample_src.sv ***
// Purpose: Sample chain model feeding monitored I/Q samples to the block.
// Assumes: Driven by the bench right after rising pclk edges.
// Notes:   Idle cycles carry the inverse of the held values.
`timescale 1ns/1ps
`default_nettype none
module shb_sample_src (
   input  wire logic                 on,    // Present a sample this cycle
   input  wire logic [15:0]          i_val, // In-phase value
   input  wire logic [15:0]          q_val, // Quadrature value
   output var shb_pkg::shb_smp_type  smp    // Sample towards the block
);
   // Stale data must never pass for a sample once the strobe is low.
   always_comb begin
      smp.valid = on;
      smp.i     = on ? i_val : ~i_val;
      smp.q     = on ? q_val : ~q_val;
   end
endmodule : shb_sample_src
`default_nettype wire

// *** sim/snapshot_histogram_binning_bench.sv ***
// Purpose: Self-checking bench for the snapshot histogram block.
// Assumes: APB master on pclk; samples come from the sample source model.
// Notes:   Bin counts are read through the bin select window.
`timescale 1ns/1ps
`default_nettype none
module snapshot_histogram_binning_bench;
   logic                     pclk = 1'b0;
   logic                     presetn = 1'b0;
   shb_pkg::shb_apb_req_type req = '0;
   logic [31:0]              prdata;
   logic                     pready;
   logic                     pslverr;
   shb_pkg::shb_smp_type     smp;
   logic                     snap_sync = 1'b0;
   logic                     irq;
   logic [2:0]               status;
   logic                     src_on = 1'b0;
   logic [15:0]              src_i = '0;
   logic [15:0]              src_q = '0;
   logic [31:0]              rd;
   logic                     err;
   int                       failures = 0;
   int                       num_checks = 0;
   logic [9:0]  b1 [5] = '{10'h000, 10'h3ff, 10'h003, 10'h103, 10'h004};
   logic [31:0] e1 [5] = '{32'h2, 32'h2, 32'h1, 32'h1, 32'h0};
   logic [1:0]  tm [4] = '{2'h1, 2'h2, 2'h3, 2'h1};
   logic [2:0]  ts [4] = '{3'h2, 3'h7, 3'h1, 3'h4};
   logic [15:0] ti [4] = '{16'h0010, 16'h7000, 16'h0100, 16'h0100};
   logic [15:0] tq [4] = '{16'h7000, 16'h1234, 16'h0000, 16'h7000};
   logic [9:0]  tb [4] = '{10'h008, 10'h048, 10'h001, 10'h020};

   always #2.5 pclk = ~pclk;

   shb_top dut (.pclk(pclk), .presetn(presetn), .apb(req), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .smp(smp), .snap_sync(snap_sync),
      .irq(irq), .status(status));
   shb_sample_src src (.on(src_on), .i_val(src_i), .q_val(src_q), .smp(smp));

   task automatic wrap_up();
      $display("checks=%0d failures=%0d", num_checks, failures);
      if (failures == 0 && num_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : wrap_up

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         failures++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk

   task automatic apb(input logic w, input logic [7:0] idx,
                      input logic [15:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      req.psel    <= 1'b1;
      req.penable <= 1'b0;
      req.pwrite  <= w;
      req.paddr   <= {2'b00, idx, 2'b00};
      req.pwdata  <= {16'h0000, d};
      @(posedge pclk);
      req.penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (n >= 50) failures++;
      rd  = prdata;
      err = pslverr;
      req.psel    <= 1'b0;
      req.penable <= 1'b0;
   endtask : apb

   task automatic rd_chk(input logic [7:0] idx, input logic [31:0] exp);
      apb(1'b0, idx, 16'h0000);
      chk(rd, exp);
   endtask : rd_chk

   task automatic wait_stat(input logic [2:0] s);
      int n;
      n = 0;
      do begin
         apb(1'b0, shb_pkg::IDX_STAT, 16'h0000);
         n++;
      end while (rd[2:0] !== s && n < 1000);
      chk(rd, {29'h0, s});
      chk({29'h0, status}, {29'h0, s});
   endtask : wait_stat

   task automatic send(input logic [15:0] i, input logic [15:0] q, int n);
      repeat (n) begin
         @(posedge pclk);
         src_on <= 1'b1;
         src_i  <= i;
         src_q  <= q;
      end
      @(posedge pclk);
      src_on <= 1'b0;
   endtask : send

   task automatic sync_pulse();
      @(posedge pclk);
      snap_sync <= 1'b1;
      @(posedge pclk);
      snap_sync <= 1'b0;
   endtask : sync_pulse

   task automatic clear_ram();
      apb(1'b1, shb_pkg::IDX_CTRL, 16'h0002);
      wait_stat(shb_pkg::STAT_OFF);
   endtask : clear_ram

   task automatic setup(input logic [15:0] lo, input logic [15:0] hi,
                        input logic [2:0] sel, input logic [15:0] tot,
                        input logic [15:0] per, input logic [1:0] mode);
      clear_ram();
      apb(1'b1, shb_pkg::IDX_LOWER, lo);
      apb(1'b1, shb_pkg::IDX_UPPER, hi);
      apb(1'b1, shb_pkg::IDX_SHIFT, {13'h0, sel});
      apb(1'b1, shb_pkg::IDX_TOTAL, tot);
      apb(1'b1, shb_pkg::IDX_PERGRP, per);
      apb(1'b1, shb_pkg::IDX_CTRL, {8'h00, mode, 6'h01});
   endtask : setup

   task automatic bin_chk(input logic [9:0] b, input logic [31:0] e);
      apb(1'b1, shb_pkg::IDX_BINSEL, {6'h0, b});
      rd_chk(shb_pkg::IDX_BINCNT, e);
   endtask : bin_chk

   initial begin
      #200000;
      failures++;
      wrap_up();
   end

   initial begin
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      rd_chk(shb_pkg::IDX_PERGRP, 32'h0000ffff);
      rd_chk(shb_pkg::IDX_SHIFT, 32'h0);
      rd_chk(shb_pkg::IDX_TOTAL, 32'h0);
      rd_chk(shb_pkg::IDX_UPPER, 32'h0);
      apb(1'b0, 8'h60, 16'h0000);
      chk({31'h0, err}, 32'h1);
      chk(rd, 32'h0);
      apb(1'b1, shb_pkg::IDX_STAT, 16'h0003);
      chk({31'h0, err}, 32'h1);
      apb(1'b1, shb_pkg::IDX_CTRL, 16'h0001);
      rd_chk(shb_pkg::IDX_STAT, 32'h0);
      // Bounds 0x10..0x400 with select 1 keep every index in range.
      setup(16'h0010, 16'h0400, 3'h1, 16'h2, 16'h3, 2'h1);
      apb(1'b1, shb_pkg::IDX_IMASK, 16'h0001);
      rd_chk(shb_pkg::IDX_STAT, 32'h1);
      send(16'h0005, 16'h0000, 2);
      sync_pulse();
      rd_chk(shb_pkg::IDX_STAT, 32'h2);
      send(16'h0005, 16'h0000, 1);
      send(16'h0010, 16'h0000, 1);
      send(16'h0500, 16'h0000, 1);
      send(16'h0400, 16'h0000, 1);
      send(16'h0013, 16'h0000, 1);
      rd_chk(shb_pkg::IDX_STAT, 32'h2);
      send(16'h0113, 16'h0000, 1);
      wait_stat(shb_pkg::STAT_DONE);
      chk({31'h0, irq}, 32'h1);
      rd_chk(shb_pkg::IDX_IFLAG, 32'h1);
      apb(1'b1, shb_pkg::IDX_IFLAG, 16'h0001);
      repeat (2) @(posedge pclk);
      chk({31'h0, irq}, 32'h0);
      for (int k = 0; k < 5; k++) begin
         bin_chk(b1[k], e1[k]);
      end
      apb(1'b1, shb_pkg::IDX_IMASK, 16'h0000);
      for (int k = 0; k < 4; k++) begin
         setup(16'h0000, 16'h7fff, ts[k], 16'h1, 16'h2, tm[k]);
         sync_pulse();
         send(ti[k], tq[k], 2);
         wait_stat(shb_pkg::STAT_DONE);
         chk({31'h0, irq}, 32'h0);
         bin_chk(tb[k], 32'h2);
      end
      wrap_up();
   end
endmodule : snapshot_histogram_binning_bench
`default_nettype wire
